// ===== inc/nvmwc_pkg.sv
// package: constants for the data nonvolatile memory write controller
package nvmwc_pkg;
  // sector 0 special function addresses (block-local choice of offsets)
  localparam logic [7:0] ADDR_OFS = 8'h1a;
  localparam logic [7:0] DATA_OFS = 8'h1b;
  localparam logic [7:0] PTR1L_OFS = 8'h01;
  localparam logic [7:0] PTR1H_OFS = 8'h02;
  localparam logic [7:0] PTR2L_OFS = 8'h03;
  localparam logic [7:0] PTR2H_OFS = 8'h04;
  localparam logic [7:0] IND1_OFS = 8'h00;
  localparam logic [7:0] IND2_OFS = 8'h05;
  // control register sits in sector 1 at this pointer value
  localparam logic [7:0] CTRL_LOW = 8'h40;
  localparam logic [7:0] CTRL_HIGH = 8'h01;
  // control bit positions
  localparam int PROG_UNLOCK_BIT = 3;
  localparam int PROG_TRIG_BIT = 2;
  localparam int FETCH_UNLOCK_BIT = 1;
  localparam int FETCH_TRIG_BIT = 0;
  // reset values
  localparam logic [7:0] ZERO_RST = 8'h00;
  // default write cycle time of the internal timer, in timer ticks
  localparam int WRITE_TICKS = 8;
  localparam int READ_CYCLES = 2;
  // state machine
  typedef enum logic [1:0] {
    NVMWC_IDLE = 2'b00,
    NVMWC_READ = 2'b01,
    NVMWC_WRITE = 2'b10
  } nvmwc_state_t;
endpackage : nvmwc_pkg

// ===== verilog/nvmwc_timer_sync.sv
// module: event synchroniser for the asynchronous write timer tick
`timescale 1ns/1ps
module nvmwc_timer_sync (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic tickLevel, // toggling level from the write timer oscillator
  output logic tickPulse // one-cycle pulse per timer edge
);
  logic syncA_reg;
  logic syncB_reg;
  logic syncC_reg;

  // two-flop synchroniser then edge detect on the settled stages only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      syncC_reg <= 1'b0;
    end else begin
      syncA_reg <= tickLevel;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end

  assign tickPulse = syncB_reg ^ syncC_reg;
endmodule : nvmwc_timer_sync

// ===== verilog/nvmwc_ctrl.sv
// module: data nonvolatile memory access controller with write timer
`timescale 1ns/1ps
// Functional notes
// - trigger ignored unless unlock already set
// - write timed by asynchronous internal timer
// - hardware clears write trigger at completion
// - power-on clears write unlock
// - power-on zeroes both pointer high bytes
// - control reached only indirectly at 01H:40H
// - bits: unlock3 trigger2 readunlock1 readtrigger0
// - write completion sets interrupt flag, a write lost to halt does not
// - vector needs both enables, stack not full
// - servicing clears interrupt flag
// - halting mid-operation aborts the operation
// - six-bit address, upper bits read zero
// - read end clears trigger, data held
module nvmwc_ctrl #(
  parameter int DEPTH = 64, // storage bytes
  parameter int WRITE_TICKS = nvmwc_pkg::WRITE_TICKS // timer ticks per write
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic nrst, // power-on reset, async, active low
  input wire logic sfrWe, // special function write strobe
  input wire logic sfrRe, // special function read strobe
  input wire logic [7:0] sfrAddr, // special function address, sector 0
  input wire logic [7:0] sfrWdata, // write data
  output logic [7:0] sfrRdata, // read data, combinational mux
  input wire logic timerTick, // free-running write timer level, async
  input wire logic globalIrqEnable, // global_irq_enable from the core
  input wire logic nvmIrqEnable, // nvm_irq_enable from the core
  input wire logic stackFull, // return stack full
  input wire logic irqServiced, // pulse: this vector taken
  input wire logic haltActive, // core in idle or sleep
  output logic irqRequest, // vector request to the core
  output logic nvmIrqFlag, // nvm_irq_flag state
  output logic writeAborted // pulse: operation lost to halt
);
  localparam int AW = $clog2(DEPTH);
  localparam int TW = $clog2(WRITE_TICKS + 1);

  initial begin
    if (DEPTH != 64) $error("nvmwc_ctrl: address register is six bits wide");
    if (WRITE_TICKS < 1) $error("nvmwc_ctrl: write time must be at least one tick");
    if (nvmwc_pkg::READ_CYCLES < 1 || nvmwc_pkg::READ_CYCLES > 4) begin
      $error("nvmwc_ctrl: read time must fit the two-bit counter");
    end
  end

  logic [7:0] mem [DEPTH];
  logic [AW-1:0] nvmAddress_reg;
  logic [7:0] nvmData_reg;
  logic [7:0] ptrOneLow_reg;
  logic [7:0] ptrOneHigh_reg;
  logic [7:0] ptrTwoLow_reg;
  logic [7:0] ptrTwoHigh_reg;
  logic programUnlock_reg;
  logic programTrig_reg;
  logic fetchUnlock_reg;
  logic fetchTrig_reg;
  logic nvmIrqFlag_reg;
  logic abort_reg;
  logic [TW-1:0] tickCount_reg;
  logic [1:0] readCount_reg;
  nvmwc_pkg::nvmwc_state_t state_reg;
  logic tickPulse;
  logic ctrlWe;
  logic ctrlHit1;
  logic ctrlHit2;
  logic writeStart;
  logic readStart;
  logic writeDone;
  logic readDone;
  logic writeEnd;
  logic readEnd;
  logic [7:0] ctrlView;

  // true when the pointer pair selects the control register in sector 1
  function automatic logic ptr_hits_ctrl(input logic [7:0] lo, input logic [7:0] hi);
    ptr_hits_ctrl = (lo == nvmwc_pkg::CTRL_LOW) && (hi == nvmwc_pkg::CTRL_HIGH);
  endfunction : ptr_hits_ctrl

  nvmwc_timer_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .tickLevel(timerTick),
    .tickPulse(tickPulse)
  );

  // control register is only reachable through an indirect port
  assign ctrlHit1 = ptr_hits_ctrl(ptrOneLow_reg, ptrOneHigh_reg);
  assign ctrlHit2 = ptr_hits_ctrl(ptrTwoLow_reg, ptrTwoHigh_reg);
  assign ctrlWe = sfrWe && (((sfrAddr == nvmwc_pkg::IND1_OFS) && ctrlHit1) ||
                            ((sfrAddr == nvmwc_pkg::IND2_OFS) && ctrlHit2));

  // a trigger counts only if unlock was already set before this write
  assign writeStart = ctrlWe && sfrWdata[nvmwc_pkg::PROG_TRIG_BIT] && programUnlock_reg &&
                      !sfrWdata[nvmwc_pkg::FETCH_TRIG_BIT] &&
                      (state_reg == nvmwc_pkg::NVMWC_IDLE) && !haltActive;
  assign readStart = ctrlWe && sfrWdata[nvmwc_pkg::FETCH_TRIG_BIT] && fetchUnlock_reg &&
                     !sfrWdata[nvmwc_pkg::PROG_TRIG_BIT] &&
                     (state_reg == nvmwc_pkg::NVMWC_IDLE) && !haltActive;
  assign writeDone = (state_reg == nvmwc_pkg::NVMWC_WRITE) && tickPulse &&
                     (tickCount_reg == TW'(WRITE_TICKS - 1)) && !haltActive;
  assign readDone = (state_reg == nvmwc_pkg::NVMWC_READ) &&
                    (readCount_reg == 2'(nvmwc_pkg::READ_CYCLES - 1)) && !haltActive;

  // an access ends on completion or is cut short by a halt
  assign writeEnd = (state_reg == nvmwc_pkg::NVMWC_WRITE) &&
                    (writeDone || haltActive);
  assign readEnd = (state_reg == nvmwc_pkg::NVMWC_READ) &&
                   (readDone || haltActive);

  // sequencer: idle, timed write, short read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= nvmwc_pkg::NVMWC_IDLE;
      tickCount_reg <= '0;
      readCount_reg <= '0;
    end else begin
      case (state_reg)
        nvmwc_pkg::NVMWC_IDLE: begin
          tickCount_reg <= '0;
          readCount_reg <= '0;
          if (writeStart) begin
            state_reg <= nvmwc_pkg::NVMWC_WRITE;
          end else if (readStart) begin
            state_reg <= nvmwc_pkg::NVMWC_READ;
          end
        end
        nvmwc_pkg::NVMWC_WRITE: begin
          // halting loses the write, the cell is left untouched
          if (haltActive || writeDone) begin
            state_reg <= nvmwc_pkg::NVMWC_IDLE;
          end else if (tickPulse) begin
            tickCount_reg <= tickCount_reg + TW'(1);
          end
        end
        nvmwc_pkg::NVMWC_READ: begin
          if (haltActive || readDone) begin
            state_reg <= nvmwc_pkg::NVMWC_IDLE;
          end else begin
            readCount_reg <= readCount_reg + 2'd1;
          end
        end
        default: begin
          state_reg <= nvmwc_pkg::NVMWC_IDLE;
        end
      endcase
    end
  end

  // unlock bits follow every software write of the control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      programUnlock_reg <= 1'b0;
      fetchUnlock_reg <= 1'b0;
    end else if (ctrlWe) begin
      programUnlock_reg <= sfrWdata[nvmwc_pkg::PROG_UNLOCK_BIT];
      fetchUnlock_reg <= sfrWdata[nvmwc_pkg::FETCH_UNLOCK_BIT];
    end
  end

  // write trigger mirrors a running write, so software cannot drop it while busy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      programTrig_reg <= 1'b0;
    end else if (writeStart) begin
      programTrig_reg <= 1'b1;
    end else if (writeEnd) begin
      programTrig_reg <= 1'b0;
    end
  end

  // read trigger drops in the cycle the fetched byte lands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetchTrig_reg <= 1'b0;
    end else if (readStart) begin
      fetchTrig_reg <= 1'b1;
    end else if (readEnd) begin
      fetchTrig_reg <= 1'b0;
    end
  end

  // memory pointers; both high bytes come up zero, keeping sector 1 out of reach
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptrOneLow_reg <= nvmwc_pkg::ZERO_RST;
      ptrOneHigh_reg <= nvmwc_pkg::ZERO_RST;
      ptrTwoLow_reg <= nvmwc_pkg::ZERO_RST;
      ptrTwoHigh_reg <= nvmwc_pkg::ZERO_RST;
    end else if (sfrWe) begin
      if (sfrAddr == nvmwc_pkg::PTR1L_OFS) ptrOneLow_reg <= sfrWdata;
      if (sfrAddr == nvmwc_pkg::PTR1H_OFS) ptrOneHigh_reg <= sfrWdata;
      if (sfrAddr == nvmwc_pkg::PTR2L_OFS) ptrTwoLow_reg <= sfrWdata;
      if (sfrAddr == nvmwc_pkg::PTR2H_OFS) ptrTwoHigh_reg <= sfrWdata;
    end
  end

  // sector 0 registers; address and data frozen while an access runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nvmAddress_reg <= '0;
      nvmData_reg <= nvmwc_pkg::ZERO_RST;
    end else begin
      if (sfrWe && state_reg == nvmwc_pkg::NVMWC_IDLE) begin
        if (sfrAddr == nvmwc_pkg::ADDR_OFS) begin
          nvmAddress_reg <= sfrWdata[AW-1:0];
        end
        if (sfrAddr == nvmwc_pkg::DATA_OFS) begin
          nvmData_reg <= sfrWdata;
        end
      end
      // fetched byte stays until the next access
      if (readDone) begin
        nvmData_reg <= mem[nvmAddress_reg];
      end
    end
  end

  // storage array; no reset since its content is nonvolatile
  always_ff @(posedge clk) begin
    if (writeDone) begin
      mem[nvmAddress_reg] <= nvmData_reg;
    end
  end

  // completion flag; the set wins over a same-cycle service clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nvmIrqFlag_reg <= 1'b0;
    end else if (writeDone) begin
      nvmIrqFlag_reg <= 1'b1;
    end else if (irqServiced) begin
      nvmIrqFlag_reg <= 1'b0;
    end
  end

  // abort indication for a write or read lost to halt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= haltActive && (state_reg != nvmwc_pkg::NVMWC_IDLE);
    end
  end

  assign irqRequest = nvmIrqFlag_reg && globalIrqEnable && nvmIrqEnable && !stackFull;
  assign nvmIrqFlag = nvmIrqFlag_reg;
  assign writeAborted = abort_reg;

  // control view: upper four bits read as zero
  assign ctrlView = {4'h0, programUnlock_reg, programTrig_reg, fetchUnlock_reg, fetchTrig_reg};

  // read mux; unmapped addresses return zero
  always_comb begin
    sfrRdata = 8'h00;
    if (sfrRe) begin
      case (sfrAddr)
        nvmwc_pkg::ADDR_OFS: sfrRdata = {{(8-AW){1'b0}}, nvmAddress_reg};
        nvmwc_pkg::DATA_OFS: sfrRdata = nvmData_reg;
        nvmwc_pkg::PTR1L_OFS: sfrRdata = ptrOneLow_reg;
        nvmwc_pkg::PTR1H_OFS: sfrRdata = ptrOneHigh_reg;
        nvmwc_pkg::PTR2L_OFS: sfrRdata = ptrTwoLow_reg;
        nvmwc_pkg::PTR2H_OFS: sfrRdata = ptrTwoHigh_reg;
        nvmwc_pkg::IND1_OFS: sfrRdata = ctrlHit1 ? ctrlView : 8'h00;
        nvmwc_pkg::IND2_OFS: sfrRdata = ctrlHit2 ? ctrlView : 8'h00;
        default: sfrRdata = 8'h00;
      endcase
    end
  end
endmodule : nvmwc_ctrl

// ===== test/nvmwc_ctrl_props.sv
// checker: port-level properties of the nvm access controller
`timescale 1ns/1ps
module nvmwc_ctrl_props (
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic sfrRe, // read strobe
  input wire logic [7:0] sfrAddr, // address
  input wire logic [7:0] sfrRdata, // read data
  input wire logic globalIrqEnable, // global enable
  input wire logic nvmIrqEnable, // nvm enable
  input wire logic stackFull, // stack full
  input wire logic irqServiced, // vector taken
  input wire logic haltActive, // idle or sleep
  input wire logic irqRequest, // vector request
  input wire logic nvmIrqFlag, // write-complete flag
  input wire logic writeAborted // abort pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // vector only with flag, both enables and room on the stack
  irq_req_a: assert property (
    irqRequest == (nvmIrqFlag && globalIrqEnable && nvmIrqEnable && !stackFull))
    else $error("vector request wrong");
  flag_clear_a: assert property (irqServiced |=> !nvmIrqFlag)
    else $error("flag not cleared");
  flag_hold_a: assert property (nvmIrqFlag && !irqServiced |=> nvmIrqFlag)
    else $error("flag dropped");
  // read bus is quiet between reads, so a stale byte never leaks
  rdata_idle_a: assert property (!sfrRe |-> sfrRdata == 8'h00)
    else $error("read data not idle");
  unmapped_read_a: assert property (sfrRe && sfrAddr == 8'h20 |-> sfrRdata == 8'h00)
    else $error("unmapped read nonzero");
  addr_upper_a: assert property (
    sfrRe && sfrAddr == nvmwc_pkg::ADDR_OFS |-> sfrRdata[7:6] == 2'b00)
    else $error("address upper bits set");
  abort_cause_a: assert property (writeAborted |-> $past(haltActive))
    else $error("abort without halt");
  store_nohalt_a: assert property ($rose(nvmIrqFlag) |-> !$past(haltActive))
    else $error("store completed under halt");
  cover property ($rose(nvmIrqFlag));
  cover property (writeAborted);
  cover property (irqRequest);
endmodule : nvmwc_ctrl_props

bind nvmwc_ctrl nvmwc_ctrl_props nvmwc_ctrl_props_inst (.clk(clk), .nrst(nrst),
  .sfrRe(sfrRe), .sfrAddr(sfrAddr), .sfrRdata(sfrRdata), .globalIrqEnable(globalIrqEnable),
  .nvmIrqEnable(nvmIrqEnable), .stackFull(stackFull), .irqServiced(irqServiced),
  .haltActive(haltActive), .irqRequest(irqRequest), .nvmIrqFlag(nvmIrqFlag),
  .writeAborted(writeAborted));

// ===== test/nvmwc_ctrl_tb_top.sv
// testbench: self-checking run of the nvm access controller
`timescale 1ns/1ps
module nvmwc_ctrl_tb_top;
  logic clk, nrst, sfrWe, sfrRe, timerTick, globalIrqEnable, nvmIrqEnable, stackFull;
  logic irqServiced, haltActive, irqRequest, nvmIrqFlag, writeAborted;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, rv, wa, wd;
  logic [7:0] expMem [64];
  logic [1:0] tickDiv;
  logic [2:0] en;
  int badCount, nCompared;
  nvmwc_ctrl #(.WRITE_TICKS(2)) nvmwc_ctrl_inst (.clk(clk), .nrst(nrst), .sfrWe(sfrWe),
    .sfrRe(sfrRe), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .timerTick(timerTick), .globalIrqEnable(globalIrqEnable), .nvmIrqEnable(nvmIrqEnable),
    .stackFull(stackFull), .irqServiced(irqServiced), .haltActive(haltActive),
    .irqRequest(irqRequest), .nvmIrqFlag(nvmIrqFlag), .writeAborted(writeAborted));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // write timer edge every four clocks; short count keeps the run brief
  always @(posedge clk) begin
    tickDiv <= tickDiv + 2'h1;
    if (tickDiv == 2'h3) timerTick <= ~timerTick;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("Error %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrWe <= 1'b1;
    sfrRe <= 1'b0;
    sfrAddr <= a;
    sfrWdata <= d;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfrWe <= 1'b0;
    sfrRe <= 1'b1;
    sfrAddr <= a;
    #1 d = sfrRdata;
    @(posedge clk);
  endtask : rd
  task automatic ctl(input logic [7:0] d);
    wr(nvmwc_pkg::IND1_OFS, d);
  endtask : ctl
  // bounded poll of one control bit; a stuck bit ends the run
  task automatic poll(input int b);
    for (int i = 0; i < 300; i++) begin
      rd(nvmwc_pkg::IND1_OFS, rv);
      if (rv[b] === 1'b0) return;
    end
    badCount++;
    $display("Error %0t: control bit stuck", $time);
    finishTest();
  endtask : poll
  task automatic doWrite(input logic [7:0] a, input logic [7:0] d, input logic ge);
    globalIrqEnable <= 1'b0;
    wr(nvmwc_pkg::ADDR_OFS, a);
    wr(nvmwc_pkg::DATA_OFS, d);
    wr(nvmwc_pkg::PTR1H_OFS, nvmwc_pkg::CTRL_HIGH);
    ctl(8'h08);
    ctl(8'h0c);
    globalIrqEnable <= ge;
    poll(2);
    chk(rv, 8'h08, "ctrl after write");
    chk({7'h0, nvmIrqFlag}, 8'h01, "flag");
    chk({7'h0, irqRequest}, {7'h0, globalIrqEnable & nvmIrqEnable & ~stackFull}, "vec");
    irqServiced <= 1'b1;
    @(posedge clk);
    irqServiced <= 1'b0;
    #1 chk({7'h0, nvmIrqFlag}, 8'h00, "flag clear");
    ctl(8'h00);
    wr(nvmwc_pkg::PTR1H_OFS, 8'h00);
    expMem[a[5:0]] = d;
  endtask : doWrite
  task automatic doRead(input logic [7:0] a);
    wr(nvmwc_pkg::ADDR_OFS, a);
    wr(nvmwc_pkg::PTR1H_OFS, nvmwc_pkg::CTRL_HIGH);
    ctl(8'h02);
    ctl(8'h03);
    poll(0);
    rd(nvmwc_pkg::DATA_OFS, rv);
    chk(rv, expMem[a[5:0]], "read back");
    rd(nvmwc_pkg::ADDR_OFS, rv);
    chk(rv, {2'b00, a[5:0]}, "address");
    ctl(8'h00);
    wr(nvmwc_pkg::PTR1H_OFS, 8'h00);
  endtask : doRead
  task automatic finishTest();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finishTest
  initial begin
    {sfrWe, sfrRe, timerTick, globalIrqEnable, nvmIrqEnable, stackFull} = '0;
    {irqServiced, haltActive, tickDiv, sfrAddr, sfrWdata} = '0;
    nrst = 1'b0;
    badCount = 0;
    nCompared = 0;
    void'($urandom(39));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(nvmwc_pkg::PTR1H_OFS, rv);
    chk(rv, 8'h00, "ptr1 high");
    rd(nvmwc_pkg::PTR2H_OFS, rv);
    chk(rv, 8'h00, "ptr2 high");
    // both pointers aimed at the control register in sector 1
    wr(nvmwc_pkg::PTR1L_OFS, nvmwc_pkg::CTRL_LOW);
    wr(nvmwc_pkg::PTR1H_OFS, nvmwc_pkg::CTRL_HIGH);
    wr(nvmwc_pkg::PTR2L_OFS, nvmwc_pkg::CTRL_LOW);
    wr(nvmwc_pkg::PTR2H_OFS, nvmwc_pkg::CTRL_HIGH);
    rd(nvmwc_pkg::IND2_OFS, rv);
    chk(rv, 8'h00, "ctrl at reset");
    // trigger alone, then unlock and trigger together: both refused
    ctl(8'h04);
    rd(nvmwc_pkg::IND1_OFS, rv);
    chk(rv, 8'h00, "lone trigger");
    ctl(8'h0c);
    rd(nvmwc_pkg::IND2_OFS, rv);
    chk(rv, 8'h08, "same-cycle trigger");
    wr(nvmwc_pkg::PTR2H_OFS, 8'h00);
    ctl(8'h00);
    for (int i = 0; i < 6; i++) begin
      wa = (i == 0) ? 8'hff : 8'($urandom);
      wd = 8'($urandom);
      en = (i == 1) ? 3'h6 : 3'($urandom);
      {nvmIrqEnable, stackFull} <= en[1:0];
      doWrite(wa, wd, en[2]);
      doRead(wa);
    end
    // pointer left in sector 0: the indirect write must not reach control
    ctl(8'h08);
    wr(nvmwc_pkg::PTR1H_OFS, nvmwc_pkg::CTRL_HIGH);
    rd(nvmwc_pkg::IND1_OFS, rv);
    chk(rv, 8'h00, "sector 0 write");
    // halt in mid-write: store lost, old byte kept
    wr(nvmwc_pkg::DATA_OFS, ~wd);
    ctl(8'h08);
    ctl(8'h0c);
    sfrWe <= 1'b0;
    haltActive <= 1'b1;
    @(posedge clk);
    haltActive <= 1'b0;
    #1 chk({7'h0, writeAborted}, 8'h01, "abort");
    repeat (30) @(posedge clk);
    rd(nvmwc_pkg::IND1_OFS, rv);
    chk(rv, 8'h08, "ctrl after abort");
    chk({7'h0, nvmIrqFlag}, 8'h00, "no flag");
    doRead(wa);
    rd(8'h20, rv);
    chk(rv, 8'h00, "unmapped");
    finishTest();
  end
endmodule : nvmwc_ctrl_tb_top
